/* bench/fpc_cache_chk.sv */
// Purpose: port-level assertions of the prefetch cache
// Assumes: bus master keeps byte enables and holds requests to completion
// Notes: keeps its own copy of cache_control from accepted writes
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_cache_chk #(
    parameter int LINES = 16,
    parameter int LINE_BITS = 128
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    input wire fpc_pkg::fpc_word_t O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic I_FETCH_REQ,
    input wire logic [31:0] I_FETCH_ADDR,
    input wire logic I_FETCH_INSTR,
    input wire logic I_FETCH_CACHEABLE,
    input wire logic O_FETCH_ACK,
    input wire fpc_pkg::fpc_word_t O_FETCH_RDATA,
    input wire logic O_FLASH_RD,
    input wire logic [31:0] O_FLASH_ADDR,
    input wire logic [LINE_BITS-1:0] I_FLASH_RDATA,
    input wire logic I_PROG_DONE
);
    import fpc_pkg::*;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    // ------
    // shadow of cache_control and flash run length
    // ------
    logic [31:0] ctrl; // expected register content
    logic [31:0] next_ctrl;
    logic [3:0] run; // cycles of the current flash access
    wire rd_ok = I_AVS_READ && !O_AVS_WAITREQUEST;
    wire wr_ctrl = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == `FPC_OFF_CTRL;
    wire mapped = I_AVS_ADDRESS inside {`FPC_OFF_CTRL, `FPC_OFF_TAG, `FPC_OFF_INDEX};
    wire [31:0] be_mask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
        {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};
    assign next_ctrl = ((ctrl & ~be_mask) | (I_AVS_WRITEDATA & be_mask)) & `FPC_CTRL_MASK;
    // shadow follows accepted writes only
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            ctrl <= `FPC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= next_ctrl;
        end
    end
    // count while the flash is read, clear between accesses
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST || !O_FLASH_RD) begin
            run <= 4'h0;
        end else begin
            run <= run + 4'h1;
        end
    end
    // ------
    // assertions
    // ------
    chk_wait_once: assert property ($rose(I_AVS_READ || I_AVS_WRITE)
        |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST) else $error("bus wait not one cycle");
    chk_wait_idle: assert property (!(I_AVS_READ || I_AVS_WRITE) |-> !O_AVS_WAITREQUEST)
        else $error("wait raised while idle");
    chk_ctrl_readback: assert property (
        rd_ok && I_AVS_ADDRESS == `FPC_OFF_CTRL |-> O_AVS_READDATA == ctrl)
        else $error("control readback wrong");
    chk_unmapped_zero: assert property (rd_ok && !mapped |-> O_AVS_READDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_wait_states: assert property (
        $fell(O_FLASH_RD) |-> run == {1'b0, ctrl[2:0]} + 4'h1)
        else $error("flash access length wrong");
    chk_ack_after_rd: assert property ($fell(O_FLASH_RD) && I_FETCH_REQ |-> O_FETCH_ACK)
        else $error("no answer after flash read");
    chk_ack_pulse: assert property (O_FETCH_ACK |=> !O_FETCH_ACK) else $error("ack too long");
    chk_ack_bound: assert property ($rose(I_FETCH_REQ) |-> ##[2:30] O_FETCH_ACK)
        else $error("fetch not answered");
    chk_flash_addr: assert property (
        $rose(O_FLASH_RD) && I_FETCH_REQ |-> O_FLASH_ADDR == {3'b000, I_FETCH_ADDR[28:4], 4'h0})
        else $error("flash line address wrong");
    chk_addr_steady: assert property (O_FLASH_RD && $past(O_FLASH_RD) |-> $stable(O_FLASH_ADDR))
        else $error("flash address moved");
    cover property ($fell(O_FLASH_RD) && run == 4'h8);
    cover property (wr_ctrl);
    cover property (I_PROG_DONE);
endmodule // fpc_cache_chk
bind fpc_cache fpc_cache_chk #(.LINES(LINES), .LINE_BITS(LINE_BITS)) i_chk (
    .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
    .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_FETCH_REQ(I_FETCH_REQ),
    .I_FETCH_ADDR(I_FETCH_ADDR), .I_FETCH_INSTR(I_FETCH_INSTR),
    .I_FETCH_CACHEABLE(I_FETCH_CACHEABLE), .O_FETCH_ACK(O_FETCH_ACK),
    .O_FETCH_RDATA(O_FETCH_RDATA), .O_FLASH_RD(O_FLASH_RD), .O_FLASH_ADDR(O_FLASH_ADDR),
    .I_FLASH_RDATA(I_FLASH_RDATA), .I_PROG_DONE(I_PROG_DONE));

/* bench/fpc_flash_model.sv */
// Purpose: behavioural program flash array behind the cache
// Assumes: same clock as the cache, line of four words
// Notes: word n of a line is its address with n in bits 3:2, scrambled
`timescale 1ns/1ps
module fpc_flash_model (
    input wire logic i_clk,
    input wire logic i_rd,
    input wire logic [31:0] i_addr,
    output logic [127:0] o_data
);
    // ------
    // line pattern
    // ------
    logic [127:0] line; // words of the addressed line
    logic [127:0] last = '0; // last line driven
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            line[32*n +: 32] = {3'b000, i_addr[28:4], n[1:0], 2'b00} ^ 32'h5A5A_5A5A;
        end
    end
    // remember what was on the bus while selected
    always_ff @(posedge i_clk) begin
        if (i_rd) begin
            last <= line;
        end
    end
    // released bus shows the inverse, so a late sample cannot pass by luck
    assign o_data = i_rd ? line : ~last;
endmodule // fpc_flash_model

/* bench/test_flash_prefetch_cache.sv */
// Purpose: self-checking bench of the prefetch cache
// Assumes: one fetch at a time, register bus with full byte enables
// Notes: flash words are predicted from the line address pattern
`timescale 1ns/1ps
`include "fpc_defs.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module test_flash_prefetch_cache;
    import fpc_pkg::*;
    logic clk, rst, av_rd, av_wr, f_req, f_ins, f_ca, f_ack, fl_rd, prog_done, av_wait;
    logic [7:0] av_addr;
    logic [31:0] av_wd, f_addr, fl_addr, rv;
    logic [3:0] av_be; // byte lanes, tied full
    fpc_word_t av_rdata, f_rdata;
    logic [127:0] fl_data;
    int n_fail = 0, compares = 0, cyc = 0, rdn, pfn, idx;
    initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
    fpc_cache i_dut (.I_REF_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(av_addr),
        .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wd),
        .I_AVS_BYTEENABLE(av_be), .O_AVS_READDATA(av_rdata), .O_AVS_WAITREQUEST(av_wait),
        .I_FETCH_REQ(f_req), .I_FETCH_ADDR(f_addr), .I_FETCH_INSTR(f_ins),
        .I_FETCH_CACHEABLE(f_ca), .O_FETCH_ACK(f_ack), .O_FETCH_RDATA(f_rdata),
        .O_FLASH_RD(fl_rd), .O_FLASH_ADDR(fl_addr), .I_FLASH_RDATA(fl_data),
        .I_PROG_DONE(prog_done));
    fpc_flash_model i_flash (.i_clk(clk), .i_rd(fl_rd), .i_addr(fl_addr), .o_data(fl_data));
    // ------
    // bus and fetch drivers
    // ------
    // hold the request until waitrequest is seen low, take data at that edge
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        av_rd <= !we;
        av_wr <= we;
        av_addr <= a;
        av_wd <= wd;
        do @(posedge clk); while (av_wait !== 1'b0);
        rv = av_rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask
    task automatic set_ctrl(input logic coh, input logic [1:0] d, p, input logic [2:0] w);
        bus(1'b1, `FPC_OFF_CTRL, {15'h0, coh, 6'h0, d, 2'h0, p, 1'b0, w});
    endtask
    // counts flash cycles up to the ack, then during a quiet tail for prefetch
    task automatic fetch(input logic [31:0] a, input logic ins, input logic ca);
        rdn = 0;
        pfn = 0;
        @(posedge clk);
        f_req <= 1'b1;
        f_addr <= a;
        f_ins <= ins;
        f_ca <= ca;
        do begin
            @(posedge clk);
            if (fl_rd === 1'b1) rdn++;
        end while (f_ack !== 1'b1);
        `CHK("fetch word", {3'b000, a[28:2], 2'b00} ^ 32'h5A5A_5A5A, f_rdata)
        f_req <= 1'b0;
        repeat (12) begin
            @(posedge clk);
            if (fl_rd === 1'b1) pfn++;
        end
    endtask
    task automatic pulse_done;
        @(posedge clk);
        prog_done <= 1'b1;
        @(posedge clk);
        prog_done <= 1'b0;
    endtask
    // scan the line index for a valid tag of this address
    task automatic find_line(input logic [31:0] a);
        for (idx = 0; idx < 16; idx++) begin
            bus(1'b1, `FPC_OFF_INDEX, 32'(idx));
            bus(1'b0, `FPC_OFF_TAG, 32'h0);
            if (rv[`FPC_VALID_BIT] === 1'b1 && rv[`FPC_LINE_ADDRESS_TAG_HI:`FPC_LINE_ADDRESS_TAG_LO] === a[23:4]) break;
        end
        `CHK("boot bit", 1'b1, rv[`FPC_BOOT_BIT])
    endtask
    // ------
    // scenarios
    // ------
    task automatic t_reset;
        bus(1'b0, `FPC_OFF_CTRL, 32'h0);
        `CHK("ctrl reset", `FPC_CTRL_RESET, rv)
        bus(1'b1, `FPC_OFF_INDEX, 32'h0000_0005);
        bus(1'b0, `FPC_OFF_TAG, 32'h0);
        `CHK("tag reset", 32'h0000_0002, rv)
        bus(1'b0, 8'h30, 32'h0);
        `CHK("unmapped", 32'h0000_0000, rv)
    endtask
    // every wait state code: miss length, then a hit with no flash access
    task automatic t_waits;
        for (int w = 0; w < 8; w++) begin
            set_ctrl(1'b0, 2'h0, 2'h0, 3'(w));
            fetch(32'h1D00_1000 + 32'(w * 68), 1'b1, 1'b1);
            `CHK("miss cycles", w + 1, rdn)
            fetch(32'h9D00_1000 + 32'(w * 68), 1'b1, 1'b1);
            `CHK("hit cycles", 0, rdn)
        end
    endtask
    // same tag bits, other region, must miss
    task automatic t_boot;
        set_ctrl(1'b0, 2'h0, 2'h0, 3'h3);
        fetch(32'h1DC0_0100, 1'b1, 1'b1);
        fetch(32'h1FC0_0100, 1'b1, 1'b1);
        `CHK("boot region miss", 4, rdn)
    endtask
    // data pool sizes; each size change drops the cached instruction line
    task automatic t_dpool;
        logic [1:0] dl [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        fetch(32'h1D00_2000, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            set_ctrl(1'b0, dl[i], 2'h0, 3'h1);
            fetch(32'h1D00_2000, 1'b1, 1'b1);
            `CHK("size change flush", 2, rdn)
            fetch(32'h1D00_3008, 1'b0, 1'b1);
            fetch(32'h1D00_3008, 1'b0, 1'b1);
            `CHK("data reuse", (dl[i] != 2'h0) ? 0 : 2, rdn)
            fetch(32'h1D00_3008, 1'b1, 1'b1);
            `CHK("type mismatch", 2, rdn)
            fetch(32'h1D00_2000, 1'b1, 1'b1);
        end
    endtask
    // every prefetch code against both region kinds
    task automatic t_pref;
        logic en;
        logic [31:0] a;
        for (int p = 0; p < 4; p++) begin
            set_ctrl(1'b0, 2'h0, 2'(p), 3'h2);
            for (int c = 0; c < 2; c++) begin
                a = 32'h1D00_4000 + 32'((p * 2 + c) * 256);
                en = (c == 1) ? p[0] : p[1];
                fetch(a, 1'b1, c[0]);
                `CHK("prefetch run", en ? 3 : 0, pfn)
                fetch(a + 32'h10, 1'b1, c[0]);
                `CHK("next line", en ? 0 : 3, rdn)
            end
        end
    endtask
    // program completion with a locked line, both coherency settings
    task automatic t_coh;
        set_ctrl(1'b0, 2'h0, 2'h0, 3'h1);
        fetch(32'h1D00_8000, 1'b1, 1'b1);
        fetch(32'h1D00_8104, 1'b1, 1'b1);
        find_line(32'h1D00_8000);
        bus(1'b1, `FPC_OFF_TAG, rv | 32'h0000_0004);
        pulse_done();
        fetch(32'h1D00_8000, 1'b1, 1'b1);
        `CHK("locked kept", 0, rdn)
        fetch(32'h1D00_8104, 1'b1, 1'b1);
        `CHK("unlocked dropped", 2, rdn)
        set_ctrl(1'b1, 2'h0, 2'h0, 3'h1);
        pulse_done();
        bus(1'b0, `FPC_OFF_TAG, 32'h0);
        `CHK("all dropped", 1'b0, rv[`FPC_VALID_BIT])
        fetch(32'h1D00_8000, 1'b1, 1'b1);
        `CHK("locked refetch", 2, rdn)
    endtask
    task report_and_stop;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard, far above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        {rst, av_rd, av_wr, f_req, f_ins, f_ca, prog_done} = 7'b100_0000;
        av_addr = 8'h00;
        av_wd = 32'h0;
        f_addr = 32'h0;
        av_be = 4'hF;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_waits();
        t_boot();
        t_dpool();
        t_pref();
        t_coh();
        report_and_stop();
    end
endmodule // test_flash_prefetch_cache

/* inc/fpc_defs.svh */
// Purpose: offsets, field positions, reset values and region bases of the prefetch cache
// Assumes: 32-bit register bus with byte addresses
// Notes: definitions only
`ifndef FPC_DEFS_SVH
`define FPC_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FPC_OFF_CTRL 8'h00
`define FPC_OFF_TAG 8'h10
`define FPC_OFF_INDEX 8'h20

// ----------------------------------------
// cache_control fields
// ----------------------------------------
`define FPC_COH_BIT 16
`define FPC_DCNT_HI 9
`define FPC_DCNT_LO 8
`define FPC_PREF_HI 5
`define FPC_PREF_LO 4
`define FPC_WS_HI 2
`define FPC_WS_LO 0
`define FPC_CTRL_RESET 32'h0000_0007
`define FPC_CTRL_MASK 32'h0001_0337

// ----------------------------------------
// line_tag fields
// ----------------------------------------
`define FPC_BOOT_BIT 31
`define FPC_LINE_ADDRESS_TAG_HI 23
`define FPC_LINE_ADDRESS_TAG_LO 4
`define FPC_VALID_BIT 3
`define FPC_LOCK_BIT 2
`define FPC_TYPE_BIT 1
`define FPC_TYPE_RESET 1'b1

// ----------------------------------------
// flash regions, physical
// ----------------------------------------
`define FPC_REGION_PROG 32'h1D00_0000
`define FPC_REGION_BOOT 32'h1FC0_0000

`endif

/* inc/fpc_pkg.sv */
// Purpose: shared types of the prefetch cache
// Assumes: nothing
// Notes: one-hot fetch states
package fpc_pkg;
    // fetch sequencer states, one-hot
    typedef enum logic [5:0] {
        FPC_IDLE = 6'b00_0001,
        FPC_RDMEM = 6'b00_0010,
        FPC_FLASH = 6'b00_0100,
        FPC_DONE = 6'b00_1000,
        FPC_PREF = 6'b01_0000,
        FPC_PFHIT = 6'b10_0000
    } fpc_state_e;
    // one 32-bit word
    typedef logic [31:0] fpc_word_t;
endpackage

/* src/fpc_cache.sv */
// Purpose: flash prefetch cache between core fetch paths and the program flash
// Assumes: 128-bit flash line per access, one fetch at a time
// Notes: registers over Avalon-MM with one wait cycle
`timescale 1ns/1ps
`include "fpc_defs.svh"
module fpc_cache #(
    parameter int LINES = 16,
    parameter int LINE_BITS = 128
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    // register bus
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output fpc_pkg::fpc_word_t O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // core fetch port
    input wire logic I_FETCH_REQ,
    input wire logic [31:0] I_FETCH_ADDR,
    input wire logic I_FETCH_INSTR,
    input wire logic I_FETCH_CACHEABLE,
    output logic O_FETCH_ACK,
    output fpc_pkg::fpc_word_t O_FETCH_RDATA,
    // flash array port
    output logic O_FLASH_RD,
    output logic [31:0] O_FLASH_ADDR,
    input wire logic [LINE_BITS-1:0] I_FLASH_RDATA,
    // completion pulse from the flash programming controller
    input wire logic I_PROG_DONE
);
    import fpc_pkg::*;

    localparam int IW = $clog2(LINES);

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [31:0] ctrl; // cache_control
    logic [IW-1:0] sel; // line picked for line_tag access
    logic bus_done; // second cycle of a bus access
    wire bus_req = I_AVS_READ | I_AVS_WRITE;
    wire bus_take = bus_req & bus_done;
    wire [31:0] be_mask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
        {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};
    wire wr_ctrl = bus_take & I_AVS_WRITE & (I_AVS_ADDRESS == `FPC_OFF_CTRL);
    wire wr_tag = bus_take & I_AVS_WRITE & (I_AVS_ADDRESS == `FPC_OFF_TAG);
    wire wr_idx = bus_take & I_AVS_WRITE & (I_AVS_ADDRESS == `FPC_OFF_INDEX);
    // unused bits masked off; software is expected to write zero there
    wire [31:0] next_ctrl = ((ctrl & ~be_mask) | (I_AVS_WRITEDATA & be_mask))
        & `FPC_CTRL_MASK;
    wire coh = ctrl[`FPC_COH_BIT];
    wire [1:0] dcnt = ctrl[`FPC_DCNT_HI:`FPC_DCNT_LO];
    wire [1:0] pref = ctrl[`FPC_PREF_HI:`FPC_PREF_LO];
    wire [2:0] ws = ctrl[`FPC_WS_HI:`FPC_WS_LO];
    // a size change wipes all lines
    wire dcnt_change = wr_ctrl
        & (next_ctrl[`FPC_DCNT_HI:`FPC_DCNT_LO] != dcnt);

    // data line budget from the size field
    wire [IW:0] dlines = (dcnt == 2'b11) ? (IW+1)'(4) :
                         (dcnt == 2'b10) ? (IW+1)'(2) :
                         (dcnt == 2'b01) ? (IW+1)'(1) : '0;

    // one wait cycle, then the access completes
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            bus_done <= 1'b0;
        end else begin
            bus_done <= bus_req & ~bus_done;
        end
    end
    assign O_AVS_WAITREQUEST = bus_req & ~bus_done;

    // control and index registers
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            ctrl <= `FPC_CTRL_RESET;
            sel <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= next_ctrl;
            end
            if (wr_idx & I_AVS_BYTEENABLE[0]) begin
                sel <= I_AVS_WRITEDATA[IW-1:0];
            end
        end
    end

    // ----------------------------------------
    // line tags
    // ----------------------------------------
    logic [19:0] line_address_tag [LINES];
    logic [LINES-1:0] boot, valid, lock, itype;
    logic [IW-1:0] age [LINES]; // 0 = most recent
    logic [LINES-1:0] hit_vec, cand_vec;

    // request address split; top bits dropped so every view maps alike
    wire [28:0] phys = I_FETCH_ADDR[28:0];
    wire req_boot = (phys[28:24] == 5'(`FPC_REGION_PROG >> 24));
    wire [19:0] req_tag = phys[`FPC_LINE_ADDRESS_TAG_HI:`FPC_LINE_ADDRESS_TAG_LO];

    // invalidation on flash program completion or a data size change
    wire inv_now = I_PROG_DONE | dcnt_change;

    // sequencer signals used by the tag update
    fpc_state_e state;
    logic [31:0] req_addr;
    logic req_instr, req_cache;
    logic [2:0] cnt;
    logic [IW-1:0] victim, hit_idx;
    logic victim_ok, hit_any;
    wire flash_last = (cnt == 3'd0);
    wire fill = (state == FPC_FLASH) & flash_last & req_cache & victim_ok & ~inv_now;
    wire touch_hit = (state == FPC_IDLE) & I_FETCH_REQ & ~inv_now & hit_any;
    wire touch = touch_hit | fill;
    wire [IW-1:0] touch_idx = touch_hit ? hit_idx : victim;
    wire [19:0] fill_tag = req_addr[`FPC_LINE_ADDRESS_TAG_HI:`FPC_LINE_ADDRESS_TAG_LO];
    wire fill_boot = (req_addr[28:24] == 5'(`FPC_REGION_PROG >> 24));

    genvar k;
    generate
        for (k = 0; k < LINES; k++) begin : g_line
            // data lines sit below the budget, instruction lines above
            wire is_dline = (IW+1)'(k) < dlines;
            // only a valid line of the right kind can hit
            assign hit_vec[k] = valid[k] & (line_address_tag[k] == req_tag)
                & (boot[k] == req_boot) & (itype[k] == I_FETCH_INSTR)
                & (I_FETCH_INSTR ? ~is_dline : is_dline);
            // locked lines never offered for refill
            assign cand_vec[k] = ~lock[k] & (req_instr ? ~is_dline : is_dline);

            // tag state per line
            always_ff @(posedge I_REF_CLK) begin
                if (I_RST) begin
                    valid[k] <= 1'b0;
                    lock[k] <= 1'b0;
                    itype[k] <= `FPC_TYPE_RESET;
                    boot[k] <= 1'b0;
                    line_address_tag[k] <= '0;
                end else if (inv_now) begin
                    // coherency bit picks which lines survive
                    if (dcnt_change | coh | ~itype[k] | ~lock[k]) begin
                        valid[k] <= 1'b0;
                    end
                end else if (wr_tag & (sel == IW'(k))) begin
                    // software load of a tag, e.g. to pre-lock a line
                    boot[k] <= I_AVS_WRITEDATA[`FPC_BOOT_BIT];
                    line_address_tag[k] <= I_AVS_WRITEDATA[`FPC_LINE_ADDRESS_TAG_HI:`FPC_LINE_ADDRESS_TAG_LO];
                    valid[k] <= I_AVS_WRITEDATA[`FPC_VALID_BIT];
                    lock[k] <= I_AVS_WRITEDATA[`FPC_LOCK_BIT];
                    itype[k] <= I_AVS_WRITEDATA[`FPC_TYPE_BIT];
                end else if (fill & (victim == IW'(k))) begin
                    valid[k] <= 1'b1;
                    line_address_tag[k] <= fill_tag;
                    boot[k] <= fill_boot;
                    itype[k] <= req_instr;
                end
            end

            // age ordering for least recently used choice
            always_ff @(posedge I_REF_CLK) begin
                if (I_RST) begin
                    age[k] <= IW'(k);
                end else if (touch) begin
                    if (touch_idx == IW'(k)) begin
                        age[k] <= '0;
                    end else if (age[k] < age[touch_idx]) begin
                        age[k] <= age[k] + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // hit encoder and victim search
    always_comb begin
        hit_any = 1'b0;
        hit_idx = '0;
        victim_ok = 1'b0;
        victim = '0;
        for (int i = 0; i < LINES; i++) begin
            if (hit_vec[i]) begin
                hit_any = 1'b1;
                hit_idx = IW'(i);
            end
            // invalid lines first, then the oldest
            if (cand_vec[i] & (~victim_ok
                | ({~valid[i], age[i]} > {~valid[victim], age[victim]}))) begin
                victim_ok = 1'b1;
                victim = IW'(i);
            end
        end
    end

    // ----------------------------------------
    // line data and prefetch buffer
    // ----------------------------------------
    logic [LINE_BITS-1:0] mem_rdata;
    logic [IW-1:0] mem_raddr;
    logic [LINE_BITS-1:0] pf_line; // predicted next line
    logic [31:0] pf_addr;
    logic pf_valid;
    wire pf_hit = pf_valid & (pf_addr[28:4] == phys[28:4]);

    fpc_line_mem #(
        .WIDTH(LINE_BITS),
        .DEPTH(LINES)
    ) u_mem (
        .i_clk(I_REF_CLK),
        .i_we(fill),
        .i_waddr(victim),
        .i_wdata(I_FLASH_RDATA),
        .i_raddr(mem_raddr),
        .o_rdata(mem_rdata)
    );

    // hit index goes straight in, so the line stands when RDMEM picks the word
    assign mem_raddr = hit_idx;

    // ----------------------------------------
    // fetch sequencer
    // ----------------------------------------
    // prefetch only after instruction fetches, in the enabled regions
    wire pf_go = req_instr & (req_cache ? pref[0] : pref[1]);
    wire [1:0] wsel = req_addr[3:2];

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            state <= FPC_IDLE;
            req_addr <= '0;
            req_instr <= 1'b0;
            req_cache <= 1'b0;
            cnt <= '0;
            O_FETCH_RDATA <= '0;
            O_FLASH_ADDR <= '0;
        end else begin
            case (state)
                FPC_IDLE: begin
                    // pending invalidation is applied before this lookup
                    if (I_FETCH_REQ & ~inv_now) begin
                        req_addr <= {3'b000, phys};
                        req_instr <= I_FETCH_INSTR;
                        req_cache <= I_FETCH_CACHEABLE;
                        if (hit_any & I_FETCH_CACHEABLE) begin
                            state <= FPC_RDMEM;
                        end else if (pf_hit) begin
                            state <= FPC_PFHIT;
                        end else begin
                            // line address, wait count from the field
                            O_FLASH_ADDR <= {3'b000, phys[28:4], 4'h0};
                            cnt <= ws;
                            state <= FPC_FLASH;
                        end
                    end
                end
                FPC_RDMEM: begin
                    O_FETCH_RDATA <= mem_rdata[32*wsel +: 32];
                    state <= FPC_DONE;
                end
                FPC_PFHIT: begin
                    O_FETCH_RDATA <= pf_line[32*wsel +: 32];
                    state <= FPC_DONE;
                end
                FPC_FLASH: begin
                    // all lines locked: word passes through uncached
                    if (flash_last) begin
                        O_FETCH_RDATA <= I_FLASH_RDATA[32*wsel +: 32];
                        state <= FPC_DONE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                FPC_DONE: begin
                    if (pf_go) begin
                        O_FLASH_ADDR <= {req_addr[31:4] + 28'd1, 4'h0};
                        cnt <= ws;
                        state <= FPC_PREF;
                    end else begin
                        state <= FPC_IDLE;
                    end
                end
                FPC_PREF: begin
                    if (flash_last) begin
                        state <= FPC_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: begin
                    state <= FPC_IDLE;
                end
            endcase
        end
    end

    // prefetch buffer; invalidation beats a landing prefetch
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            pf_valid <= 1'b0;
            pf_line <= '0;
            pf_addr <= '0;
        end else if (inv_now) begin
            pf_valid <= 1'b0;
        end else if ((state == FPC_PREF) & flash_last) begin
            pf_valid <= 1'b1;
            pf_line <= I_FLASH_RDATA;
            pf_addr <= O_FLASH_ADDR;
        end
    end

    assign O_FETCH_ACK = (state == FPC_DONE);
    assign O_FLASH_RD = (state == FPC_FLASH) | (state == FPC_PREF);

    // ----------------------------------------
    // register read path
    // ----------------------------------------
    wire [31:0] tag_view = {boot[sel], 7'd0, line_address_tag[sel], valid[sel],
        lock[sel], itype[sel], 1'b0};
    wire [31:0] rd_mux = (I_AVS_ADDRESS == `FPC_OFF_CTRL) ? ctrl :
                         (I_AVS_ADDRESS == `FPC_OFF_TAG) ? tag_view :
                         (I_AVS_ADDRESS == `FPC_OFF_INDEX) ? 32'(sel) : '0;

    // data loaded in the wait cycle, stand at the completing edge
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            O_AVS_READDATA <= '0;
        end else if (I_AVS_READ & ~bus_done) begin
            O_AVS_READDATA <= rd_mux;
        end
    end
endmodule // fpc_cache

/* src/fpc_line_mem.sv */
// Purpose: data store of the cache lines
// Assumes: one write and one read port on the same clock
// Notes: read data come from a register, one cycle after the address
`timescale 1ns/1ps
module fpc_line_mem #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [WIDTH-1:0] mem [DEPTH]; // no reset: validity lives in the tags

    // write port
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // registered read, same-cycle write returns old data
    always_ff @(posedge i_clk) begin
        o_rdata <= mem[i_raddr];
    end
endmodule // fpc_line_mem
